/* File: hw/sync_volt_freq_converter_pkg.sv */
// Package of constants for the gated-count converter controller
// Functional notes
// RQ1: Converter samples on fall, outputs on rise
// RQ2: At most one converter pulse per two clocks
// RQ3: Gate derived from the converter clock itself
// RQ4: Count converter pulses throughout each gate
// RQ5: Gate lasts 2N converter clock cycles
// RQ6: Binary divider chain makes the gate
// RQ7: Support N of 4096,10000,16384,20000,65536
// RQ8: Gate chosen as multiple of line period
// RQ9: Delta mode idles at quarter clock rate
// RQ10: Delta rate rises or falls with input slope
// RQ11: Capture isolated converter pulses in flip-flop
// RQ12: Chopper drive divides by two, complementary
// RQ13: Converter clock equals chopper frequency, 125 kHz
// RQ14: Decoders use inverted clock phases per channel
// RQ15: Clear count at gate start, hold at end
package sync_volt_freq_converter_pkg;
  // System clock rate
  localparam int unsigned CLK_HZ          = 40000000;
  // Converter and chopper clock rate
  localparam int unsigned CONV_CLK_HZ     = 125000;
  // System cycles per converter clock half period
  localparam int unsigned CONV_HALF_CYC   = CLK_HZ / (2 * CONV_CLK_HZ);
  // Width of the half-period counter
  localparam int unsigned HALF_W          = 8;
  // Result width, wide enough for N of 65536
  localparam int unsigned RES_W           = 17;
  // Code-count selections
  localparam logic [2:0]  NSEL_4096       = 3'h0;
  localparam logic [2:0]  NSEL_10000      = 3'h1;
  localparam logic [2:0]  NSEL_16384      = 3'h2;
  localparam logic [2:0]  NSEL_20000      = 3'h3;
  localparam logic [2:0]  NSEL_65536      = 3'h4;
  // Code counts
  localparam logic [16:0] N_4096          = 17'h01000;
  localparam logic [16:0] N_10000         = 17'h02710;
  localparam logic [16:0] N_16384         = 17'h04000;
  localparam logic [16:0] N_20000         = 17'h04E20;
  localparam logic [16:0] N_65536         = 17'h10000;
  // Gate controller states
  typedef enum logic [1:0] {SYNC_VOLT_FREQ_CONVERTER_IDLE, SYNC_VOLT_FREQ_CONVERTER_GATE} sync_volt_freq_converter_state_t;
endpackage

/* File: hw/sync_volt_freq_converter_sync.sv */
// Two-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module sync_volt_freq_converter_sync (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_q;  // First stage, read only by second
  logic meta_d;
  logic sync_q;  // Second stage
  logic sync_d;
  // Next values
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end
  // Registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      // Rest at the pull-up level so no false step follows reset
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign o_sync = sync_q;
endmodule
`default_nettype wire

/* File: hw/sync_volt_freq_converter_clkgen.sv */
// Divider that makes the converter clock and chopper drive
`timescale 1ns/1ps
`default_nettype none
module sync_volt_freq_converter_clkgen #(
  parameter int unsigned HALF_CYC = sync_volt_freq_converter_pkg::CONV_HALF_CYC
) (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  output logic      o_conv_clk,
  output logic      o_rise,
  output logic      o_fall
);
  logic [sync_volt_freq_converter_pkg::HALF_W-1:0] cnt_q;  // Half-period counter
  logic [sync_volt_freq_converter_pkg::HALF_W-1:0] cnt_d;
  logic                        clk_q;  // Converter clock level
  logic                        clk_d;
  logic                        rise_q; // Pulse with the rising edge
  logic                        rise_d;
  logic                        fall_q; // Pulse with the falling edge
  logic                        fall_d;
  localparam int unsigned                 LAST_I = HALF_CYC - 1;  // Last count value
  localparam logic [sync_volt_freq_converter_pkg::HALF_W-1:0] LAST   = LAST_I[sync_volt_freq_converter_pkg::HALF_W-1:0];
  // Toggle the clock every half period for an exact 50% duty
  always_comb begin
    cnt_d  = cnt_q + 1'b1;
    clk_d  = clk_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (cnt_q == LAST) begin
      cnt_d  = '0;
      clk_d  = ~clk_q; // RQ12
      rise_d = ~clk_q;
      fall_d = clk_q;
    end
  end
  // Registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q  <= '0;
      clk_q  <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      clk_q  <= clk_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end
  assign o_conv_clk = clk_q;
  assign o_rise     = rise_q;
  assign o_fall     = fall_q;
endmodule
`default_nettype wire

/* File: hw/sync_volt_freq_converter_gated_count_adc.sv */
// Gated pulse counter that turns the converter into an A-to-D converter
`timescale 1ns/1ps
`default_nettype none
module sync_volt_freq_converter_gated_count_adc #(
  parameter int unsigned HALF_CYC = sync_volt_freq_converter_pkg::CONV_HALF_CYC,
  parameter int unsigned RES_W    = sync_volt_freq_converter_pkg::RES_W
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  input  wire logic             i_start,      // Start one conversion (pulse)
  input  wire logic             i_continuous, // Restart after every gate
  input  wire logic [2:0]       i_nsel,       // Code-count selection
  input  wire logic             i_freq_out,   // Converter open-collector output
  output logic                  o_conv_clk,   // Converter clock
  output logic                  o_chop_p,     // Chopper drive, true phase
  output logic                  o_chop_n,     // Chopper drive, inverted phase
  output logic                  o_conv_clk_n, // Inverted phase for decoders
  output logic                  o_busy,       // Gate open
  output logic                  o_done,       // Result valid pulse
  output logic                  o_overrange,  // Count exceeded rate bound
  output logic [RES_W-1:0]      o_result      // Held conversion result
);
  // Overview of operation
  // The converter clock is made here by an even divider of the system
  // clock, so the gate and the converter run from one time base.
  // A slow drift of the system clock stretches the gate and lowers the
  // converter full-scale rate by the same factor, so the count, being
  // a ratio of the two, does not move with it.
  // Clock path
  // The divider toggles its level every HALF_CYC system cycles.
  // It also gives one-cycle strobes that line up with its own rise
  // and fall, so the counting logic never looks at a derived clock.
  // The same level drives the chopper pair and the decoder phase.
  // All pins leave through one more flop each, so they move together
  // one system cycle after the strobes.
  // Pulse path
  // The converter output is open collector with a pull-up, so the line
  // idles high and a pulse is a low level of one converter clock.
  // The pin passes a two-flop synchroniser first.
  // The synchronised level is latched once per converter clock, on the
  // rise strobe, which is before the pin flop moves the clock pin high.
  // The value latched therefore belongs to the converter period that
  // just ended, and the line has had most of a full converter period to settle.
  // A pulse is taken as a high-to-low step between two latched values,
  // judged on the fall strobe, so one low period counts exactly once.
  // Gate path
  // A start, or the continuous level, is taken only on a rise strobe.
  // That aligns the gate with the converter clock; a start held across
  // several strobes still opens one gate, since the gate is busy then.
  // The gate length is 2N converter clocks, loaded from the selection.
  // The counter is cleared as the gate opens and copied to the result
  // register as it closes; the done strobe marks that copy.
  // A start that arrives while the gate is open is ignored.
  // Rate check
  // The converter cannot legally give two pulses on adjacent clocks.
  // If that is seen inside a gate, the overrange flag is raised and
  // held until the next gate opens, so software sees it with the
  // result of the gate in which it happened.
  // Limits
  // The pulse must stay low for at least one latch point, so the
  // converter one-shot must not be set shorter than a converter clock
  // minus the synchroniser delay.
  // HALF_CYC must be at least two, or the synchroniser delay would
  // reach past the next latch point.
  // The result register is RES_W bits, which holds the largest code
  // count plus one without wrapping.
  // Changing the selection while the gate is open has no effect on the
  // running gate; it is read only when the gate opens.
  // Reset
  // The outside reset is applied at once and released through two
  // flops, so every register leaves reset on the same system edge.
  // The inverted pins rest high in reset so the pairs stay opposite.
  logic rst_a_q;  // Reset release stage one
  logic rst_b_q;  // Reset release stage two
  logic rstn;     // Released reset
  // Reset release through two flops
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end
  assign rstn = rst_b_q;

  logic clk_lvl;   // Converter clock level
  logic clk_rise;  // Rising edge pulse
  logic clk_fall;  // Falling edge pulse
  // Converter clock and chopper drive share one 125 kHz source
  sync_volt_freq_converter_clkgen #(
    .HALF_CYC (HALF_CYC)
  ) u_clkgen (
    .i_mclk     (i_mclk),
    .i_rstn     (rstn),
    .o_conv_clk (clk_lvl),
    .o_rise     (clk_rise),
    .o_fall     (clk_fall)
  ); // RQ13

  logic fo_sync;  // Synchronised converter output
  // Pin passes two flops before any logic
  sync_volt_freq_converter_sync u_sync (
    .i_mclk  (i_mclk),
    .i_rstn  (rstn),
    .i_async (i_freq_out),
    .o_sync  (fo_sync)
  );

  // Gate state
  sync_volt_freq_converter_pkg::sync_volt_freq_converter_state_t st_q;
  sync_volt_freq_converter_pkg::sync_volt_freq_converter_state_t st_d;
  logic [RES_W:0]   gate_q;   // Converter clocks left in gate
  logic [RES_W:0]   gate_d;
  logic [RES_W-1:0] cnt_q;    // Pulse counter
  logic [RES_W-1:0] cnt_d;
  logic [RES_W-1:0] res_q;    // Held result
  logic [RES_W-1:0] res_d;
  logic             done_q;
  logic             done_d;
  logic             ovr_q;
  logic             ovr_d;
  logic             cap_q;    // Captured output level
  logic             cap_d;
  logic             prev_q;   // Previous captured level
  logic             prev_d;
  logic             lastp_q;  // Pulse seen on previous converter clock
  logic             lastp_d;
  logic             pulse;    // New pulse this converter falling edge
  logic [16:0]      ncodes;   // Selected N
  logic [RES_W:0]   gate_len; // 2N converter clocks

  // Select the code count
  always_comb begin
    case (i_nsel)
      sync_volt_freq_converter_pkg::NSEL_4096:  ncodes = sync_volt_freq_converter_pkg::N_4096;
      sync_volt_freq_converter_pkg::NSEL_10000: ncodes = sync_volt_freq_converter_pkg::N_10000;
      sync_volt_freq_converter_pkg::NSEL_16384: ncodes = sync_volt_freq_converter_pkg::N_16384;
      sync_volt_freq_converter_pkg::NSEL_20000: ncodes = sync_volt_freq_converter_pkg::N_20000;
      sync_volt_freq_converter_pkg::NSEL_65536: ncodes = sync_volt_freq_converter_pkg::N_65536;
      default:              ncodes = sync_volt_freq_converter_pkg::N_4096;
    endcase // RQ7
    // Gate time is the converter clock period times 2N; pick the clock
    // so that this is a whole number of line periods
    gate_len = (RES_W+1)'({ncodes, 1'b0}); // RQ5 RQ8
  end

  // Converter output is active low; judge the levels latched on the rise a half period later, on the fall
  assign pulse = clk_fall & ~cap_q & prev_q; // RQ1

  // Gate and counting logic
  always_comb begin
    st_d    = st_q;
    gate_d  = gate_q;
    cnt_d   = cnt_q;
    res_d   = res_q;
    done_d  = 1'b0;
    ovr_d   = ovr_q;
    cap_d   = cap_q;
    prev_d  = prev_q;
    lastp_d = lastp_q;
    // Latch the isolated output once per converter clock
    if (clk_rise) begin
      prev_d = cap_q;
      cap_d  = fo_sync; // RQ11
    end
    case (st_q)
      sync_volt_freq_converter_pkg::SYNC_VOLT_FREQ_CONVERTER_IDLE: begin
        if ((i_start || i_continuous) && clk_rise) begin
          st_d    = sync_volt_freq_converter_pkg::SYNC_VOLT_FREQ_CONVERTER_GATE;
          gate_d  = gate_len;   // RQ3
          cnt_d   = '0;         // RQ15
          ovr_d   = 1'b0;
          lastp_d = 1'b0;
        end
      end
      sync_volt_freq_converter_pkg::SYNC_VOLT_FREQ_CONVERTER_GATE: begin
        if (pulse) begin
          cnt_d   = cnt_q + 1'b1; // RQ4
          lastp_d = 1'b1;
          // Back-to-back pulses break the half-clock bound
          if (lastp_q) begin
            ovr_d = 1'b1; // RQ2
          end
        end else if (clk_fall) begin
          lastp_d = 1'b0;
        end
        if (clk_rise) begin
          gate_d = gate_q - 1'b1; // RQ6
          if (gate_q == (RES_W+1)'(1)) begin
            st_d   = sync_volt_freq_converter_pkg::SYNC_VOLT_FREQ_CONVERTER_IDLE;
            res_d  = cnt_q;        // RQ15
            done_d = 1'b1;
          end
        end
      end
      default: begin
        st_d = sync_volt_freq_converter_pkg::SYNC_VOLT_FREQ_CONVERTER_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= sync_volt_freq_converter_pkg::SYNC_VOLT_FREQ_CONVERTER_IDLE;
      gate_q  <= '0;
      cnt_q   <= '0;
      res_q   <= '0;
      done_q  <= 1'b0;
      ovr_q   <= 1'b0;
      cap_q   <= 1'b1;
      prev_q  <= 1'b1;
      lastp_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      gate_q  <= gate_d;
      cnt_q   <= cnt_d;
      res_q   <= res_d;
      done_q  <= done_d;
      ovr_q   <= ovr_d;
      cap_q   <= cap_d;
      prev_q  <= prev_d;
      lastp_q <= lastp_d;
    end
  end

  // Output flops for clocks and chopper phases
  logic cclk_q;   // Converter clock pin
  logic cclk_d;
  logic cclkn_q;  // Inverted phase pin
  logic cclkn_d;
  logic chp_q;    // Chopper true phase pin
  logic chp_d;
  logic chn_q;    // Chopper inverted phase pin
  logic chn_d;
  logic busy_q;   // Gate open pin
  logic busy_d;
  // Next values of the pin flops; all phases move on one system edge
  always_comb begin
    cclk_d  = clk_lvl;
    cclkn_d = ~clk_lvl;  // RQ14
    chp_d   = clk_lvl;   // RQ12
    chn_d   = ~clk_lvl;
    busy_d  = (st_d == sync_volt_freq_converter_pkg::SYNC_VOLT_FREQ_CONVERTER_GATE);
  end
  // Pin registers; the inverted phases rest high in reset
  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      cclk_q  <= 1'b0;
      cclkn_q <= 1'b1;
      chp_q   <= 1'b0;
      chn_q   <= 1'b1;
      busy_q  <= 1'b0;
    end else begin
      cclk_q  <= cclk_d;
      cclkn_q <= cclkn_d;
      chp_q   <= chp_d;
      chn_q   <= chn_d;
      busy_q  <= busy_d;
    end
  end

  assign o_conv_clk   = cclk_q;
  assign o_conv_clk_n = cclkn_q;
  assign o_chop_p     = chp_q;
  assign o_chop_n     = chn_q;
  assign o_busy       = busy_q;
  assign o_done       = done_q;
  assign o_overrange  = ovr_q;
  assign o_result     = res_q;
endmodule
`default_nettype wire

/* File: testbench/sync_volt_freq_converter_chk.sv */
// Port checker of the gated pulse counter
`timescale 1ns/1ps
`default_nettype none
module sync_volt_freq_converter_chk #(
  parameter int unsigned HALF_CYC = 2,
  parameter int unsigned RES_W    = 17
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  input  wire logic [2:0]       i_nsel,
  input  wire logic             o_conv_clk,
  input  wire logic             o_chop_p,
  input  wire logic             o_chop_n,
  input  wire logic             o_conv_clk_n,
  input  wire logic             o_busy,
  input  wire logic             o_done,
  input  wire logic             o_overrange,
  input  wire logic [RES_W-1:0] o_result
);
  logic [31:0] half_q; // Cycles since the converter clock last moved
  logic [31:0] gate_q; // Cycles the gate has been open
  logic        clk_q;  // Converter clock one cycle ago
  logic        seen_q; // A converter clock edge has been seen
  logic [16:0] n_codes; // Code count of the present selection
  // Code count picked by the selection, unlisted codes give 4096
  always_comb begin
    case (i_nsel)
      sync_volt_freq_converter_pkg::NSEL_10000: n_codes = sync_volt_freq_converter_pkg::N_10000;
      sync_volt_freq_converter_pkg::NSEL_16384: n_codes = sync_volt_freq_converter_pkg::N_16384;
      sync_volt_freq_converter_pkg::NSEL_20000: n_codes = sync_volt_freq_converter_pkg::N_20000;
      sync_volt_freq_converter_pkg::NSEL_65536: n_codes = sync_volt_freq_converter_pkg::N_65536;
      default:              n_codes = sync_volt_freq_converter_pkg::N_4096;
    endcase
  end
  // Counters of clock half periods and of gate length
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      half_q <= '0;
      gate_q <= '0;
      clk_q  <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      half_q <= (o_conv_clk != clk_q) ? 32'h0 : half_q + 32'h1;
      gate_q <= o_busy ? gate_q + 32'h1 : 32'h0;
      clk_q  <= o_conv_clk;
      seen_q <= seen_q | (o_conv_clk != clk_q);
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  chk_chop_compl:
    assert property (o_chop_p != o_chop_n) else $error("chopper phases equal");
  chk_dec_phase:
    assert property (o_conv_clk_n == !o_conv_clk) else $error("decoder phase wrong");
  chk_half_period:
    assert property (seen_q && (o_conv_clk != clk_q) |-> half_q == HALF_CYC - 1)
      else $error("converter clock half period wrong");
  chk_gate_len:
    assert property ($fell(o_busy) |-> gate_q == 4 * HALF_CYC * n_codes)
      else $error("gate length wrong");
  chk_done_end:
    assert property ($fell(o_busy) |-> ##[0:3] o_done) else $error("no done at gate end");
  chk_done_pulse:
    assert property (o_done |-> !o_busy ##1 !o_done) else $error("done not one pulse");
  chk_result_hold:
    assert property ($changed(o_result) |-> o_done) else $error("result moved without done");
  chk_count_bound:
    assert property (o_done && !o_overrange |-> o_result <= n_codes)
      else $error("count above full scale");
  chk_ovr_clear:
    assert property ($rose(o_busy) |-> ##[0:1] !o_overrange) else $error("overrange kept");
endmodule
bind sync_volt_freq_converter_gated_count_adc sync_volt_freq_converter_chk #(.HALF_CYC(HALF_CYC), .RES_W(RES_W)) u_chk (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_nsel(i_nsel), .o_conv_clk(o_conv_clk),
  .o_chop_p(o_chop_p), .o_chop_n(o_chop_n), .o_conv_clk_n(o_conv_clk_n),
  .o_busy(o_busy), .o_done(o_done), .o_overrange(o_overrange), .o_result(o_result));
`default_nettype wire

/* File: testbench/sync_volt_freq_converter_conv_model.sv */
// Behavioural converter frequency output
`timescale 1ns/1ps
`default_nettype none
module sync_volt_freq_converter_conv_model (
  input  wire logic       i_conv_clk, // Converter clock from the controller
  input  wire logic [3:0] i_period,   // Converter clocks per output pulse
  output logic            o_freq_out  // Open-collector output, low is a pulse
);
  logic [3:0] cnt_q;  // Clocks since the last pulse
  logic       fire_q; // Comparator decision caught on the falling edge
  initial begin
    cnt_q = 4'h0;
    fire_q = 1'b0;
    o_freq_out = 1'b1;
  end
  // Decision taken on the falling edge, pulse rate at most half the clock for a period of two or more
  // A shorter period raises the rate toward full scale, a longer lowers it
  always @(negedge i_conv_clk) begin
    fire_q <= (cnt_q + 4'h1 >= i_period);
    cnt_q <= (cnt_q + 4'h1 >= i_period) ? 4'h0 : cnt_q + 4'h1;
  end
  // Shown on the next rising edge, pull-up level when no pulse
  always @(posedge i_conv_clk) o_freq_out <= !fire_q;
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench of the gated counter controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned HC = 2; // Shortened converter half period
  logic i_mclk = 1'b0, i_rstn = 1'b0, i_start = 1'b0, i_continuous = 1'b0;
  logic [2:0]  i_nsel = 3'h0;  // Code-count selection
  logic [3:0]  period = 4'h2;  // Model pulse spacing
  logic o_conv_clk, o_chop_p, o_chop_n, o_conv_clk_n, o_busy, o_done, o_overrange;
  logic [16:0] o_result;
  wire logic   freq_out;       // Converter output line
  int mismatches = 0, checks = 0, cyc = 0;
  sync_volt_freq_converter_gated_count_adc #(.HALF_CYC(HC), .RES_W(17)) uut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(i_start), .i_continuous(i_continuous),
    .i_nsel(i_nsel), .i_freq_out(freq_out), .o_conv_clk(o_conv_clk),
    .o_chop_p(o_chop_p), .o_chop_n(o_chop_n), .o_conv_clk_n(o_conv_clk_n),
    .o_busy(o_busy), .o_done(o_done), .o_overrange(o_overrange), .o_result(o_result));
  sync_volt_freq_converter_conv_model u_conv (.i_conv_clk(o_conv_clk), .i_period(period), .o_freq_out(freq_out));
  initial forever #12.5 i_mclk = ~i_mclk;
  // Cut a hang short
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      $display("CHECK FAILED %0t %s", $time, msg);
      mismatches++;
    end
  endtask
  // Wait a bounded time for a level on busy or done
  task automatic wait_for(input bit on_done);
    int n;
    n = 0;
    while ((on_done ? o_done : o_busy) !== 1'b1 && n < 40000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
  endtask
  task automatic t_reset_vals();
    check({o_conv_clk, o_chop_p, o_busy, o_done, o_overrange} === 5'h00, "not idle");
    check({o_chop_n, o_conv_clk_n} === 2'h3, "inverted phases low");
    check(o_result === 17'h00000, "result not cleared");
  endtask
  // Full-scale rate, with a refused start inside the gate
  task automatic t_full();
    @(posedge i_mclk);
    period <= 4'h2;
    i_nsel <= sync_volt_freq_converter_pkg::NSEL_4096;
    i_start <= 1'b1;
    wait_for(1'b0);
    @(posedge i_mclk) i_start <= 1'b0;
    check(o_busy === 1'b1, "gate did not open");
    repeat (100) @(posedge i_mclk);
    i_start <= 1'b1;
    repeat (10) @(posedge i_mclk);
    i_start <= 1'b0;
    wait_for(1'b1);
    check(o_result >= 17'h00FFF && o_result <= 17'h01000, "full scale count");
    check(o_overrange === 1'b0, "overrange at legal rate");
    repeat (50) @(posedge i_mclk);
    #1;
    check(o_busy === 1'b0, "extra gate after refused start");
  endtask
  // Steady delta rate in continuous mode, then a reset inside a gate
  task automatic t_cont();
    @(posedge i_mclk);
    period <= 4'h4;
    i_nsel <= 3'h5;
    i_continuous <= 1'b1;
    wait_for(1'b1);
    check(o_result >= 17'h007FF && o_result <= 17'h00800, "half scale count");
    @(posedge i_mclk);
    #1;
    wait_for(1'b0);
    check(o_busy === 1'b1, "no restart");
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    i_continuous <= 1'b0;
    #1;
    t_reset_vals();
    repeat (16) @(posedge i_mclk);
    i_rstn <= 1'b1;
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    t_reset_vals();
    i_rstn <= 1'b1;
    repeat (8) @(posedge i_mclk);
    t_full();
    t_cont();
    repeat (20) @(posedge i_mclk);
    #1;
    check(o_busy === 1'b0, "busy after reset");
    conclude();
  end
endmodule
`default_nettype wire
